//--- hdl/scr_config_regs.sv
// configuration register pair with self test and write-safety busy flag
//
// How it works
// - setup register at 0x0a, read/write
// - shutter bit 0 laser on, 1 gated
// - self test bit starts test, signature published
// - loaded patch memory forces failing signature
// - laser fault during test forces failure
// - test end restores registers and patch defaults
// - test lasts 200ms at 24MHz clock
// - two cpi bits select 400/800/1600/2000
// - extended register 0x0b, reset 0x08, busy bit
// - setup bit7 zero, bit3 one, bits 1:0 reserved
// - busy two frames after bound upper write, ignored during self test
// - pull-up disable turns off pin current sources
// - gain loop disable fixes shutter at bound
`timescale 1ns/1ps
module scr_config_regs
    import scr_pkg::*;
#(
    parameter int TEST_CYCLES = SCR_TEST_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [6:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    input wire logic bound_upper_wr,
    input wire logic frame_tick,
    input wire logic patch_loaded,
    input wire logic laser_fault_pin,
    input wire logic illum_needed,
    output logic laser_on,
    output logic [1:0] cpi_select,
    output logic pullup_disable,
    output logic gain_loop_disable,
    output logic frame_rate_lock,
    output logic test_running,
    output logic patch_restore
);
    logic fault_s1_ff;
    logic fault_s2_ff;
    logic [7:0] setup_ff;
    logic [7:0] nxt_setup;
    logic [7:0] setup_wr_val;
    logic [2:0] ext_ff;
    logic [2:0] nxt_ext;
    logic [1:0] busy_cnt_ff;
    logic [1:0] nxt_busy_cnt;
    logic [7:0] rd_ff;
    logic [7:0] nxt_rd;
    logic restore_ff;
    logic nxt_restore;
    logic test_done;
    logic [15:0] signature;

    // the sequencer needs distinct first and last cycles
    if (TEST_CYCLES < 2) begin : g_cycles_check
        $error("TEST_CYCLES must be at least 2");
    end

    wire logic sel_setup = (addr == SCR_ADDR_SETUP);
    wire logic sel_ext = (addr == SCR_ADDR_SETUP_EXT);
    wire logic sel_lo = (addr == SCR_ADDR_RESULT_LO);
    wire logic sel_hi = (addr == SCR_ADDR_RESULT_HI);
    // port is deaf during a test, so a stray access cannot corrupt it
    wire logic wr_ok = wr_en && !test_running;
    wire logic rd_ok = rd_en && !test_running;
    wire logic setup_wr = wr_ok && sel_setup;
    wire logic ext_wr = wr_ok && sel_ext;
    wire logic test_start = setup_wr && wr_data[SCR_BIT_SELFTEST];
    wire logic test_bit = test_start || (test_running && !test_done);
    wire logic busy = (busy_cnt_ff != 2'h0);
    wire logic busy_load = bound_upper_wr && !test_running;
    wire logic busy_step = frame_tick && busy;

    // field taps, so the outputs read as the register map does
    wire logic shutter_gated = setup_ff[SCR_BIT_SHUTTER];
    wire logic cpi_upper = setup_ff[SCR_BIT_CPI_UPPER];
    wire logic cpi_lower = setup_ff[SCR_BIT_CPI_LOWER];
    wire logic [2:0] ext_wr_val = wr_data[2:0];
    wire logic [7:0] ext_rd_val = {busy, 3'h0, 1'b1, ext_ff};
    wire logic [7:0] sig_lo = signature[7:0];
    wire logic [7:0] sig_hi = signature[15:8];

    // fault comes from the pin, so it is synchronised first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fault_s1_ff <= 1'b0;
        end else begin
            fault_s1_ff <= laser_fault_pin;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fault_s2_ff <= 1'b0;
        end else begin
            fault_s2_ff <= fault_s1_ff;
        end
    end

    scr_self_test #(
        .TEST_CYCLES(TEST_CYCLES)
    ) u_test (
        .clk(clk),
        .rst_n(rst_n),
        .start(test_start),
        .patch_loaded(patch_loaded),
        .laser_fault(fault_s2_ff),
        .running(test_running),
        .done(test_done),
        .signature(signature)
    );

    // fixed bits forced so a careless write cannot break them
    always_comb begin
        setup_wr_val = wr_data;
        setup_wr_val[SCR_BIT_ZERO] = 1'b0;
        setup_wr_val[SCR_BIT_ONE] = 1'b1;
        setup_wr_val[1:0] = 2'h0;
    end

    // a finished test overrides everything with the defaults
    always_comb begin
        if (test_done) begin
            nxt_setup = SCR_SETUP_RESET;
        end else if (setup_wr) begin
            nxt_setup = setup_wr_val;
        end else begin
            nxt_setup = setup_ff;
        end
        // the test bit is a trigger; it reads high only while running
        nxt_setup[SCR_BIT_SELFTEST] = test_bit;
    end

    always_comb begin
        if (test_done) begin
            nxt_ext = SCR_EXT_RESET[2:0];
        end else if (ext_wr) begin
            nxt_ext = ext_wr_val;
        end else begin
            nxt_ext = ext_ff;
        end
    end

    // a new bound write restarts the wait even mid-count
    always_comb begin
        if (busy_load) begin
            nxt_busy_cnt = 2'(SCR_BUSY_FRAMES);
        end else if (busy_step) begin
            nxt_busy_cnt = busy_cnt_ff - 2'h1;
        end else begin
            nxt_busy_cnt = busy_cnt_ff;
        end
    end

    // refused reads leave the last answer standing
    assign nxt_rd = !rd_ok ? rd_ff
        : sel_setup ? setup_ff
        : sel_ext ? ext_rd_val
        : sel_lo ? sig_lo
        : sel_hi ? sig_hi
        : 8'h00;
    assign nxt_restore = test_done;

    // one short register block per piece of state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            setup_ff <= SCR_SETUP_RESET;
        end else begin
            setup_ff <= nxt_setup;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_ff <= SCR_EXT_RESET[2:0];
        end else begin
            ext_ff <= nxt_ext;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_cnt_ff <= 2'h0;
        end else begin
            busy_cnt_ff <= nxt_busy_cnt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_ff <= 8'h00;
        end else begin
            rd_ff <= nxt_rd;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            restore_ff <= 1'b0;
        end else begin
            restore_ff <= nxt_restore;
        end
    end

    // laser gate stays combinational so light is not a cycle late
    assign rd_data = rd_ff;
    assign laser_on = !shutter_gated || illum_needed;
    assign cpi_select = {cpi_lower, cpi_upper};
    assign pullup_disable = ext_ff[SCR_BIT_PULLUP_DIS];
    assign gain_loop_disable = ext_ff[SCR_BIT_GAIN_DIS];
    assign frame_rate_lock = ext_ff[SCR_BIT_FR_LOCK];
    assign patch_restore = restore_ff;
endmodule : scr_config_regs

//--- hdl/scr_self_test.sv
// self test sequencer producing the 16 bit signature
`timescale 1ns/1ps
module scr_self_test
    import scr_pkg::*;
#(
    parameter int TEST_CYCLES = SCR_TEST_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic patch_loaded,
    input wire logic laser_fault,
    output logic running,
    output logic done,
    output logic [15:0] signature
);
    if (TEST_CYCLES < 2) begin : g_cycles_check
        $error("TEST_CYCLES must be at least 2");
    end

    typedef enum logic [0:0] {ST_IDLE, ST_RUN} scr_st_e;
    scr_st_e state_ff, nxt_state;
    logic [31:0] cnt_ff, nxt_cnt;
    logic fail_ff, nxt_fail;
    logic done_ff, nxt_done;
    logic [15:0] sig_ff, nxt_sig;
    wire logic last = (cnt_ff == 32'(TEST_CYCLES - 1));

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_fail = fail_ff;
        nxt_done = 1'b0;
        nxt_sig = sig_ff;
        case (state_ff)
            ST_IDLE: begin
                if (start) begin
                    nxt_state = ST_RUN;
                    nxt_cnt = '0;
                    nxt_fail = patch_loaded;
                end
            end
            ST_RUN: begin
                nxt_cnt = cnt_ff + 32'h1;
                if (laser_fault) nxt_fail = 1'b1;
                if (last) begin
                    nxt_state = ST_IDLE;
                    nxt_done = 1'b1;
                    nxt_sig = (fail_ff || laser_fault) ? SCR_SIG_FAIL
                                                      : SCR_SIG_PASS;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
            fail_ff <= 1'b0;
            done_ff <= 1'b0;
            sig_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            fail_ff <= nxt_fail;
            done_ff <= nxt_done;
            sig_ff <= nxt_sig;
        end
    end

    // refusal also covers the restore cycle, so no write is lost to it
    assign running = (state_ff == ST_RUN) || done_ff;
    assign done = done_ff;
    assign signature = sig_ff;
endmodule : scr_self_test

//--- include/scr_pkg.sv
// constants for the sensor configuration register pair
package scr_pkg;
    localparam logic [6:0] SCR_ADDR_SETUP = 7'h0a;
    localparam logic [6:0] SCR_ADDR_SETUP_EXT = 7'h0b;
    localparam logic [6:0] SCR_ADDR_RESULT_LO = 7'h0c;
    localparam logic [6:0] SCR_ADDR_RESULT_HI = 7'h0d;
    localparam logic [7:0] SCR_SETUP_RESET = 8'h49;
    localparam logic [7:0] SCR_EXT_RESET = 8'h08;
    localparam int SCR_BIT_ZERO = 7;
    localparam int SCR_BIT_SHUTTER = 6;
    localparam int SCR_BIT_SELFTEST = 5;
    localparam int SCR_BIT_CPI_UPPER = 4;
    localparam int SCR_BIT_ONE = 3;
    localparam int SCR_BIT_CPI_LOWER = 2;
    localparam int SCR_BIT_BUSY = 7;
    localparam int SCR_BIT_PULLUP_DIS = 2;
    localparam int SCR_BIT_GAIN_DIS = 1;
    localparam int SCR_BIT_FR_LOCK = 0;
    localparam logic [1:0] SCR_CPI_400 = 2'h0;
    localparam logic [1:0] SCR_CPI_800 = 2'h1;
    localparam logic [1:0] SCR_CPI_1600 = 2'h2;
    localparam logic [1:0] SCR_CPI_2000 = 2'h3;
    localparam int SCR_TEST_TIME_MS = 200;
    localparam int SCR_TEST_CLK_MHZ = 24;
    localparam int SCR_CLK_MHZ = 40;
    // test length not scaled to our 40MHz clock: 200ms worth of 24MHz cycles
    localparam int SCR_TEST_CYCLES =
        SCR_TEST_TIME_MS * SCR_TEST_CLK_MHZ * 1000;
    localparam int SCR_BUSY_FRAMES = 2;
    localparam logic [15:0] SCR_SIG_PASS = 16'ha9d5;
    localparam logic [15:0] SCR_SIG_FAIL = 16'h0000;
endpackage : scr_pkg

//--- verif/scr_config_regs_monitor.sv
// assertion checker for the configuration register pair
`timescale 1ns/1ps
module scr_config_regs_monitor #(
    parameter int TEST_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [6:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic laser_on,
    input wire logic [1:0] cpi_select,
    input wire logic pullup_disable,
    input wire logic gain_loop_disable,
    input wire logic frame_rate_lock,
    input wire logic test_running,
    input wire logic patch_restore
);
    localparam int TMAX = TEST_CYCLES + 2;
    int run_len;
    // running spans the counted cycles plus the restore cycle
    always @(posedge clk) begin
        if (!rst_n) run_len <= 0;
        else if (test_running) run_len <= run_len + 1;
        else run_len <= 0;
    end
    wire setup_wr = wr_en && !test_running && addr == 7'h0a;
    wire ext_wr = wr_en && !test_running && addr == 7'h0b;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    cpi_write_a: assert property (setup_wr |=>
        cpi_select == {$past(wr_data[2]), $past(wr_data[4])})
        else $error("cpi select does not follow write");
    laser_steady_a: assert property (setup_wr && !wr_data[6] |=>
        laser_on) else $error("laser off with shutter mode off");
    pullup_write_a: assert property (ext_wr |=>
        pullup_disable == $past(wr_data[2])) else $error("pullup bit");
    gain_write_a: assert property (ext_wr |=>
        gain_loop_disable == $past(wr_data[1])) else $error("gain bit");
    frame_lock_a: assert property (ext_wr |=>
        frame_rate_lock == $past(wr_data[0])) else $error("frame bit");
    test_start_a: assert property (setup_wr && wr_data[5] |=>
        test_running) else $error("self test did not start");
    test_length_a: assert property ($rose(test_running) |->
        test_running[*8] ##[1:TMAX] !test_running)
        else $error("self test length wrong");
    test_restore_a: assert property ($fell(test_running) |->
        ##[0:1] patch_restore) else $error("no restore after test");
    busy_refuse_a: assert property (test_running && rd_en |=>
        $stable(rd_data)) else $error("read served during test");
    test_cycles_a: assert property ($fell(test_running) |->
        run_len == TEST_CYCLES + 1)
        else $error("self test cycle count wrong");
endmodule : scr_config_regs_monitor

//--- verif/scr_host_model.sv
// controller model driving the register port
`timescale 1ns/1ps
module scr_host_model (
    input wire logic clk,
    input wire logic test_running,
    input wire logic [7:0] rd_data,
    output logic wr_en,
    output logic rd_en,
    output logic [6:0] addr,
    output logic [7:0] wr_data
);
    bit rude = 1'b0;
    initial begin
        {wr_en, rd_en, addr, wr_data} = '0;
    end
    // stays off the port during self test unless told to misbehave
    task automatic acc(input bit w, input logic [6:0] a,
        input logic [7:0] d, output logic [7:0] q);
        do begin
            @(posedge clk);
            #1;
        end while (test_running && !rude);
        {wr_en, rd_en, addr, wr_data} = {w, !w, a, d};
        @(posedge clk);
        #1;
        {wr_en, rd_en} = 2'b00;
        q = rd_data;
    endtask : acc
endmodule : scr_host_model

//--- verif/tb_scr_config_regs.sv
// self-checking bench for the configuration register pair
`timescale 1ns/1ps
module tb_scr_config_regs;
    import scr_pkg::*;
    localparam int TEST_CYCLES = 20;
    logic clk, rst_n, wr_en, rd_en, bound_upper_wr, frame_tick;
    logic patch_loaded, laser_fault_pin, illum_needed, laser_on;
    logic pullup_disable, gain_loop_disable, frame_rate_lock;
    logic test_running, patch_restore;
    logic [6:0] addr;
    logic [7:0] wr_data, rd_data, q;
    logic [1:0] cpi_select;
    int errors = 0;
    int total_checks = 0;
    scr_config_regs #(.TEST_CYCLES(TEST_CYCLES)) dut_u (.*);
    scr_host_model host_u (.*);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string n, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        host_u.acc(1'b0, a, 8'h00, q);
        chk("rd_data", {8'h00, e}, {8'h00, q});
    endtask : rd_chk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_u.acc(1'b1, a, d, q);
    endtask : wr
    task automatic self_test(input logic [15:0] sig);
        @(posedge clk);
        #1;
        rst_n = 1'b0; // reset right before the
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        rd_chk(SCR_ADDR_SETUP, SCR_SETUP_RESET);
        wr(SCR_ADDR_SETUP, 8'h28);
        host_u.rude = 1'b1;
        rd_chk(SCR_ADDR_RESULT_LO, SCR_SETUP_RESET); // refused read
        host_u.rude = 1'b0;
        rd_chk(SCR_ADDR_RESULT_HI, sig[15:8]);
        rd_chk(SCR_ADDR_RESULT_LO, sig[7:0]);
        rd_chk(SCR_ADDR_SETUP, SCR_SETUP_RESET);
        wr(SCR_ADDR_SETUP_EXT, 8'h0d); // settings after the
        rd_chk(SCR_ADDR_SETUP_EXT, 8'h0d);
    endtask : self_test
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        print_verdict;
    end
    initial begin
        {rst_n, bound_upper_wr, frame_tick} = 3'b000;
        {patch_loaded, laser_fault_pin, illum_needed} = 3'b000;
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        rd_chk(SCR_ADDR_SETUP, SCR_SETUP_RESET);
        rd_chk(SCR_ADDR_SETUP_EXT, SCR_EXT_RESET);
        rd_chk(7'h00, 8'h00); // unmapped address
        for (int i = 0; i < 4; i++) begin
            wr(SCR_ADDR_SETUP, {3'b010, i[0], 1'b1, i[1], 2'b00});
            rd_chk(SCR_ADDR_SETUP, {3'b010, i[0], 1'b1, i[1], 2'b00});
            chk("cpi_select", 16'(i), {14'h0, cpi_select});
        end
        chk("laser_on", 16'h0, {15'h0, laser_on}); // gated, dark
        illum_needed = 1'b1;
        #1 chk("laser_on", 16'h1, {15'h0, laser_on});
        wr(SCR_ADDR_SETUP, 8'h08);
        illum_needed = 1'b0;
        #1 chk("laser_on", 16'h1, {15'h0, laser_on}); // always on
        wr(SCR_ADDR_SETUP_EXT, 8'h0f);
        rd_chk(SCR_ADDR_SETUP_EXT, 8'h0f);
        chk("ext pins", 16'h7, {13'h0, pullup_disable, gain_loop_disable,
            frame_rate_lock});
        wr(SCR_ADDR_SETUP_EXT, 8'hf0); // fixed bits must not stick
        rd_chk(SCR_ADDR_SETUP_EXT, 8'h08);
        @(posedge clk);
        #1 bound_upper_wr = 1'b1;
        @(posedge clk);
        #1 bound_upper_wr = 1'b0;
        rd_chk(SCR_ADDR_SETUP_EXT, 8'h88);
        for (int f = 0; f < 2; f++) begin
            @(posedge clk);
            #1 frame_tick = 1'b1;
            @(posedge clk);
            #1 frame_tick = 1'b0;
            rd_chk(SCR_ADDR_SETUP_EXT, f ? 8'h08 : 8'h88);
        end
        self_test(SCR_SIG_PASS);
        patch_loaded = 1'b1;
        self_test(SCR_SIG_FAIL);
        patch_loaded = 1'b0;
        laser_fault_pin = 1'b1;
        self_test(SCR_SIG_FAIL);
        print_verdict;
    end
endmodule : tb_scr_config_regs
bind scr_config_regs scr_config_regs_monitor
    #(.TEST_CYCLES(TEST_CYCLES)) mon_u (.*);
